// File: rtl/status_flag_pkg.sv
// How it works
// - rate converter bad config raises error flag
// - rate converter error latches on rising edge
// - pin shows overheat warning or shutdown
// - headphone shorted if either region flags
// - overheat or speaker short kills speaker driver
// - speaker shutdown flag after shutdown completes
// - protection flags latch events on edges
// - range control flags on codes 1Dh-26h
// - sequencer active while running or queued
// - code 15h pulses about 100ns at done
// - sequence completion latches an event
// - bad register address sets interface error
// - firmware access without clock is error
// - interface error latches on rising edge
// - clock enable status codes, shutdown events
// - underclocked error when clock too slow
// - overclocked error beyond device limits
// - reject starved path, keep active paths
// - clocking errors latch on both edges
// - latched bit clears only on one written
package status_flag_pkg;
   // apb register map (byte addresses)
   localparam logic [11:0] ADDR_CFG    = 12'h000;
   localparam logic [11:0] ADDR_PIN    = 12'h004;
   localparam logic [11:0] ADDR_RAW    = 12'h008;
   localparam logic [11:0] ADDR_EVT    = 12'h00C;
   localparam logic [11:0] ADDR_PATH   = 12'h010;
   localparam logic [11:0] ADDR_FWACC  = 12'h014;
   // cfg register fields
   localparam int CFG_MAIN_EN = 0;
   localparam int CFG_SEC_EN  = 1;
   localparam logic [31:0] CFG_RESET = 32'h0000_0000;
   // raw/event bit positions
   localparam int NFLAG      = 16;
   localparam int B_ISRC0    = 0;
   localparam int B_WARN     = 3;
   localparam int B_OVHT     = 4;
   localparam int B_SPK_SC   = 5;
   localparam int B_HP_SC    = 6;
   localparam int B_SPK_OFF  = 8;
   localparam int B_SEQ_DONE = 9;
   localparam int B_CIF_ERR  = 10;
   localparam int B_MAIN_ON  = 11;
   localparam int B_SEC_ON   = 12;
   localparam int B_UNDER    = 13;
   localparam int B_OVER     = 14;
   localparam int B_SEQ_BSY  = 15;
   // pin function codes
   localparam logic [7:0] FN_SEQ_DONE = 8'h15;
   localparam logic [7:0] FN_CIF_ERR  = 8'h16;
   localparam logic [7:0] FN_DRC_LO   = 8'h1D;
   localparam logic [7:0] FN_DRC_HI   = 8'h26;
   localparam logic [7:0] FN_UNDER    = 8'h0A;
   localparam logic [7:0] FN_OVER_A   = 8'h27;
   localparam logic [7:0] FN_OVER_B   = 8'h2E;
   localparam logic [7:0] FN_WARN     = 8'h2B;
   localparam logic [7:0] FN_OVHT     = 8'h2C;
   localparam logic [7:0] FN_MAIN_ON  = 8'h4B;
   localparam logic [7:0] FN_SEC_ON   = 8'h4C;
   localparam logic [7:0] FN_ISOCHRONOUS_RATE_CONVERTER_LO  = 8'h4D;
   localparam logic [7:0] FN_SPK_SC   = 8'h53;
   localparam logic [7:0] FN_HP_SC_LO = 8'h54;
   localparam logic [7:0] FN_HP_SC_HI = 8'h55;
   localparam logic [7:0] FN_SPK_OFF  = 8'h56;
   // pulse timing
   localparam int CLK_NS     = 100;
   localparam int PULSE_NS   = 100;
   localparam int PULSE_CYC  = (PULSE_NS + CLK_NS / 2) / CLK_NS > 0 ?
                               (PULSE_NS + CLK_NS / 2) / CLK_NS : 1;
   localparam int SHUT_CYC   = 4;
   // apb request bundle
   typedef struct packed {
      logic        sel;
      logic        en;
      logic        wr;
      logic [11:0] addr;
      logic [31:0] wdata;
   } apb_req_t;
endpackage

// File: rtl/pulse_stretch.sv
`timescale 1ns/1ns
`default_nettype none
// holds output high for a fixed count after a trigger
module pulse_stretch #(
   parameter int CYCLES = 1
) (
   input  wire logic i_sys_clk,
   input  wire logic i_rstn,
   input  wire logic i_trig,
   output logic      o_pulse
);
   typedef struct packed {
      logic [7:0] cnt;
   } ps_state_t;
   ps_state_t s_q;
   ps_state_t s_d;

   // load on trigger, count down otherwise
   always_comb begin
      s_d = s_q;
      if (i_trig) begin
         s_d.cnt = 8'(CYCLES);
      end else if (s_q.cnt != 8'h00) begin
         s_d.cnt = s_q.cnt - 8'h01;
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign o_pulse = (s_q.cnt != 8'h00);
endmodule
`default_nettype wire

// File: rtl/status_flag_event_sources.sv
// The implementer's own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ns
`default_nettype none
// gathers status flags, latches edge events, drives two pins
module status_flag_event_sources #(
   parameter int NPIN = 2
) (
   input  wire logic        i_sys_clk,
   input  wire logic        i_rstn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // sources
   input  wire logic [2:0]  i_isochronous_rate_converter_bad,
   input  wire logic        i_temp_warn,
   input  wire logic        i_temp_shut,
   input  wire logic        i_spk_short,
   input  wire logic [1:0]  i_hp_short_pos,
   input  wire logic [1:0]  i_hp_short_neg,
   input  wire logic [9:0]  i_drc_flags,
   input  wire logic        i_seq_running,
   input  wire logic        i_seq_queued,
   input  wire logic        i_seq_done,
   input  wire logic        i_fw_clk_on,
   input  wire logic [7:0]  i_clk_need,
   input  wire logic [7:0]  i_clk_avail,
   input  wire logic [7:0]  i_clk_limit,
   // outputs
   output logic             o_spk_enable,
   output logic [7:0]       o_path_active,
   output logic             o_main_clk_en,
   output logic             o_sec_clk_en,
   output logic [NPIN-1:0]  o_pin
);
   localparam int N = status_flag_pkg::NFLAG;

   // edge kinds per flag bit: rising, falling
   // clock-on bits latch on the fall only: the event marks a finished
   // shutdown, not a start; busy (bit 15) never latches
   localparam logic [N-1:0] RISE_MASK = 16'h67FF;
   localparam logic [N-1:0] FALL_MASK = 16'h7800;

   typedef struct packed {
      logic [31:0]       cfg;       // clock enables
      logic [15:0]       pin_fn;    // two 8-bit function codes
      logic [N-1:0]      raw;       // previous flag levels
      logic [N-1:0]      evt;       // latched events
      logic [7:0]        path;      // active signal paths
      logic              cif_err;   // control interface error level
      logic              spk_off;   // speaker shutdown done
      logic [3:0]        shut_cnt;  // speaker shutdown progress
      logic              main_on;   // main clock functions live
      logic              sec_on;    // secondary clock functions live
      logic              busy_q;    // sequencer active, delayed
      logic [31:0]       rdata;
   } st_t;
   st_t s_q;
   st_t s_d;

   logic [N-1:0] flags;
   logic         hp_sc;
   logic         shut_req;
   logic         under_err;
   logic         over_err;
   logic         seq_busy;
   logic         all_done;
   logic         done_pulse;
   logic         acc;

   // pick one flag for a pin by function code
   function automatic logic pin_mux(input logic [7:0] fn,
                                    input logic [N-1:0] f,
                                    input logic [9:0] dynamic_range_control,
                                    input logic hpp,
                                    input logic hpn,
                                    input logic pls);
      logic r;
      r = 1'b0;
      if (fn >= status_flag_pkg::FN_DRC_LO &&
          fn <= status_flag_pkg::FN_DRC_HI) begin
         r = dynamic_range_control[4'(fn - status_flag_pkg::FN_DRC_LO)];
      end else if (fn >= status_flag_pkg::FN_ISOCHRONOUS_RATE_CONVERTER_LO &&
                   fn <= 8'h4F) begin
         r = f[2'(fn - status_flag_pkg::FN_ISOCHRONOUS_RATE_CONVERTER_LO)];
      end else begin
         case (fn)
            status_flag_pkg::FN_SEQ_DONE: r = pls;
            status_flag_pkg::FN_CIF_ERR:  r = f[status_flag_pkg::B_CIF_ERR];
            status_flag_pkg::FN_WARN:     r = f[status_flag_pkg::B_WARN];
            status_flag_pkg::FN_OVHT:     r = f[status_flag_pkg::B_OVHT];
            status_flag_pkg::FN_SPK_SC:   r = f[status_flag_pkg::B_SPK_SC];
            status_flag_pkg::FN_HP_SC_LO: r = hpp;
            status_flag_pkg::FN_HP_SC_HI: r = hpn;
            status_flag_pkg::FN_SPK_OFF:  r = f[status_flag_pkg::B_SPK_OFF];
            status_flag_pkg::FN_MAIN_ON:  r = f[status_flag_pkg::B_MAIN_ON];
            status_flag_pkg::FN_SEC_ON:   r = f[status_flag_pkg::B_SEC_ON];
            status_flag_pkg::FN_UNDER:    r = f[status_flag_pkg::B_UNDER];
            status_flag_pkg::FN_OVER_A:   r = f[status_flag_pkg::B_OVER];
            status_flag_pkg::FN_OVER_B:   r = f[status_flag_pkg::B_OVER];
            default:                      r = 1'b0;
         endcase
      end
      return r;
   endfunction

   // headphone short on any channel: either region counts
   assign hp_sc = |(i_hp_short_pos | i_hp_short_neg);
   // overheat or speaker short forces shutdown
   assign shut_req = i_temp_shut | i_spk_short;
   // clock checks for the current demand
   assign over_err  = i_clk_need > i_clk_limit;
   assign under_err = !over_err && (i_clk_need > i_clk_avail);
   assign seq_busy  = i_seq_running | i_seq_queued;
   // done only when nothing runs or waits
   assign all_done  = s_q.busy_q && !seq_busy;

   // flag vector in bit order of the event register
   always_comb begin
      flags = '0;
      flags[2:0]                        = i_isochronous_rate_converter_bad;
      flags[status_flag_pkg::B_WARN]    = i_temp_warn;
      flags[status_flag_pkg::B_OVHT]    = i_temp_shut;
      flags[status_flag_pkg::B_SPK_SC]  = i_spk_short;
      flags[status_flag_pkg::B_HP_SC]   = hp_sc;
      flags[status_flag_pkg::B_SPK_OFF] = s_q.spk_off;
      flags[status_flag_pkg::B_SEQ_DONE]= i_seq_done;
      flags[status_flag_pkg::B_CIF_ERR] = s_q.cif_err;
      flags[status_flag_pkg::B_MAIN_ON] = s_q.main_on;
      flags[status_flag_pkg::B_SEC_ON]  = s_q.sec_on;
      flags[status_flag_pkg::B_UNDER]   = under_err;
      flags[status_flag_pkg::B_OVER]    = over_err;
      flags[status_flag_pkg::B_SEQ_BSY] = seq_busy;
   end

   pulse_stretch #(
      .CYCLES (status_flag_pkg::PULSE_CYC)
   ) u_done_pulse (
      .i_sys_clk (i_sys_clk),
      .i_rstn    (i_rstn),
      .i_trig    (all_done),
      .o_pulse   (done_pulse)
   );

   assign acc = psel && penable;

   // next state: bus, events, shutdown sequencing
   always_comb begin
      logic [N-1:0] rise;
      logic [N-1:0] fall;
      logic [N-1:0] clr;
      logic [11:0]  a;
      logic         hit;
      rise = flags & ~s_q.raw;
      fall = ~flags & s_q.raw;
      clr  = '0;
      a    = paddr;
      hit  = 1'b1;
      s_d  = s_q;
      s_d.raw    = flags;
      s_d.busy_q = seq_busy;
      s_d.cif_err = 1'b0;
      // register access: read word prepared in setup, writes on access
      if (psel) begin
         case (a)
            status_flag_pkg::ADDR_CFG: begin
               if (acc && pwrite) s_d.cfg = pwdata;
               s_d.rdata = s_q.cfg;
            end
            status_flag_pkg::ADDR_PIN: begin
               if (acc && pwrite) s_d.pin_fn = pwdata[15:0];
               s_d.rdata = {16'h0000, s_q.pin_fn};
            end
            status_flag_pkg::ADDR_RAW: begin
               s_d.rdata = {16'h0000, flags};
            end
            status_flag_pkg::ADDR_EVT: begin
               if (acc && pwrite) clr = pwdata[N-1:0];
               s_d.rdata = {16'h0000, s_q.evt};
            end
            status_flag_pkg::ADDR_PATH: begin
               // only grant paths that fit the clock budget
               if (acc && pwrite && !under_err && !over_err) begin
                  s_d.path = pwdata[7:0];
               end
               s_d.rdata = {24'h00_0000, s_q.path};
            end
            status_flag_pkg::ADDR_FWACC: begin
               // firmware window dead without its clock
               hit = i_fw_clk_on;
               s_d.rdata = 32'h0000_0000;
            end
            default: begin
               hit = 1'b0;
               s_d.rdata = 32'h0000_0000;
            end
         endcase
         // hold the answer through the access phase so it stands at
         // the edge where the master takes it
         if (penable) s_d.rdata = s_q.rdata;
         if (acc && !hit) s_d.cif_err = 1'b1;
      end
      // latch events; new edge beats a same-cycle clear
      s_d.evt = (s_q.evt & ~clr) |
                (rise & RISE_MASK) |
                (fall & FALL_MASK);
      // clock enables go live and drop one cycle after the cfg bits
      s_d.main_on = s_q.cfg[status_flag_pkg::CFG_MAIN_EN];
      s_d.sec_on  = s_q.cfg[status_flag_pkg::CFG_SEC_EN];
      // speaker shutdown: count up driver ramp to SHUT_CYC
      if (shut_req) begin
         if (s_q.shut_cnt != 4'(status_flag_pkg::SHUT_CYC)) begin
            s_d.shut_cnt = s_q.shut_cnt + 4'h1;
         end else begin
            s_d.spk_off = 1'b1;
         end
      end else begin
         s_d.shut_cnt = 4'h0;
         s_d.spk_off  = 1'b0;
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // always single-cycle access phase; read word loaded at setup edge
   assign pready  = 1'b1;
   assign pslverr = 1'b0;
   assign prdata  = s_q.rdata;
   // driver is off from the first cycle of a fault
   assign o_spk_enable  = !shut_req && !s_q.spk_off;
   assign o_path_active = s_q.path;
   assign o_main_clk_en = s_q.main_on;
   assign o_sec_clk_en  = s_q.sec_on;

   // pin selectors
   always_comb begin
      o_pin = '0;
      for (int i = 0; i < NPIN; i++) begin
         o_pin[i] = pin_mux(s_q.pin_fn[i*8 +: 8], flags, i_drc_flags,
                            i_hp_short_pos[0] | i_hp_short_neg[0],
                            i_hp_short_pos[1] | i_hp_short_neg[1],
                            done_pulse);
      end
   end
endmodule
`default_nettype wire

// File: verification/status_flag_properties.sv
`timescale 1ns/1ns
`default_nettype none
// watches bus answers, clock enables, paths and the speaker cut-off
module status_flag_checker (
   input wire logic        i_sys_clk,
   input wire logic        i_rstn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        i_temp_shut,
   input wire logic        i_spk_short,
   input wire logic        o_spk_enable,
   input wire logic [7:0]  o_path_active,
   input wire logic        o_main_clk_en,
   input wire logic        o_sec_clk_en
);
   // single domain, so one clock and one reset for all
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_rstn);
   logic wr_acc;  // write access edge
   assign wr_acc = psel && penable && pwrite;
   a_ready_high: assert property (pready)
      else $error("pready low");
   a_no_slverr: assert property (!pslverr)
      else $error("pslverr raised");
   a_temp_cut: assert property (i_temp_shut |-> !o_spk_enable)
      else $error("speaker on during overheat");
   a_short_cut: assert property (i_spk_short |-> !o_spk_enable)
      else $error("speaker on during short");
   a_main_follow: assert property (wr_acc && paddr == 12'h000 |=> ##1
      o_main_clk_en == $past(pwdata[0], 2)) else $error("main enable wrong");
   a_sec_follow: assert property (wr_acc && paddr == 12'h000 |=> ##1
      o_sec_clk_en == $past(pwdata[1], 2)) else $error("sec enable wrong");
   a_path_cause: assert property (!$stable(o_path_active) |->
      $past(wr_acc && paddr == 12'h010)) else $error("path changed alone");
   a_rd_hold: assert property (!(psel && !penable) |=> $stable(prdata))
      else $error("read data moved");
endmodule
bind status_flag_event_sources status_flag_checker u_status_flag_checker (
   .i_sys_clk, .i_rstn, .psel, .penable, .pwrite, .paddr, .pwdata,
   .prdata, .pready, .pslverr, .i_temp_shut, .i_spk_short,
   .o_spk_enable, .o_path_active, .o_main_clk_en, .o_sec_clk_en);
`default_nettype wire

// File: verification/pin_watch.sv
`timescale 1ns/1ns
`default_nettype none
// pin selector side: counts high cycles and rising edges of a pin
module pin_watch (
   input wire logic  i_sys_clk,
   input wire logic  i_rstn,
   input wire logic  i_pin,
   output logic [7:0] o_high,
   output logic [7:0] o_rises
);
   logic prev_q;  // last pin level, for edge finding
   // counters wrap; the bench only uses differences
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         prev_q  <= 1'b0;
         o_high  <= 8'h00;
         o_rises <= 8'h00;
      end else begin
         prev_q  <= i_pin;
         o_high  <= o_high + 8'(i_pin);
         o_rises <= o_rises + 8'(i_pin && !prev_q);
      end
   end
endmodule
`default_nettype wire

// File: verification/test_status_flag_event_sources.sv
`timescale 1ns/1ns
`default_nettype none
// drives bus and sources, queues expected reads for the monitor
module test_status_flag_event_sources;
   logic        i_sys_clk, i_rstn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [2:0]  i_isochronous_rate_converter_bad;
   logic        i_temp_warn, i_temp_shut, i_spk_short, i_fw_clk_on;
   logic [1:0]  i_hp_short_pos, i_hp_short_neg, o_pin;
   logic [9:0]  i_drc_flags;
   logic        i_seq_running, i_seq_queued, i_seq_done;
   logic [7:0]  i_clk_need, i_clk_avail, i_clk_limit, o_path_active;
   logic        o_spk_enable, o_main_clk_en, o_sec_clk_en;
   logic [7:0]  w_high, w_rises;
   logic [63:0] notes [$];  // mask and expected value per read
   int          mismatches, n_tests, seed;
   status_flag_event_sources u_status_flag_event_sources (.i_sys_clk,
      .i_rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .i_isochronous_rate_converter_bad, .i_temp_warn, .i_temp_shut, .i_spk_short,
      .i_hp_short_pos, .i_hp_short_neg, .i_drc_flags, .i_seq_running,
      .i_seq_queued, .i_seq_done, .i_fw_clk_on, .i_clk_need, .i_clk_avail,
      .i_clk_limit, .o_spk_enable, .o_path_active, .o_main_clk_en,
      .o_sec_clk_en, .o_pin);
   pin_watch u_pin_watch (.i_sys_clk, .i_rstn, .i_pin(o_pin[0]),
      .o_high(w_high), .o_rises(w_rises));
   task automatic conclude();
      $display("checks %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: word %h not %h", $time, got, exp);
      end
   endtask
   task automatic cmp_pin(input logic got, input logic exp);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: level %b not %b", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge i_sys_clk);
   endtask
   // one apb transfer; for a read d is the expected value under m
   task automatic bus(input logic w, input logic [11:0] a,
                      input logic [31:0] d, input logic [31:0] m);
      int k;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= w ? d : 32'h0000_0000;
      if (!w) notes.push_back({m, d & m});
      @(posedge i_sys_clk);
      penable <= 1'b1;
      for (k = 0; k < 20; k++) begin
         @(posedge i_sys_clk);
         if (pready === 1'b1) break;
      end
      if (k == 20) begin
         mismatches++;
         conclude();
      end
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge i_sys_clk);
   endtask
   initial begin
      i_sys_clk = 1'b0;
      forever #50 i_sys_clk = ~i_sys_clk;
   end
   // read data taken at the edge where pready is sampled high
   always @(posedge i_sys_clk) begin : monitor
      logic [63:0] nt;  // oldest note: mask and expected value
      if (psel && penable && !pwrite && pready) begin
         if (notes.size() == 0) begin
            cmp_pin(1'b1, 1'b0);
         end else begin
            nt = notes.pop_front();
            cmp_reg(prdata & nt[63:32], nt[31:0]);
         end
      end
   end
   initial begin : main
      logic [9:0] r;
      logic [7:0] codes [8];
      logic [7:0] h0, r0;
      int         i;
      codes = '{8'h4D, 8'h4E, 8'h4F, 8'h2B, 8'h2C, 8'h53, 8'h54, 8'h55};
      seed = 32'h518c_43a3;
      {psel, penable, pwrite, paddr, pwdata, i_isochronous_rate_converter_bad, i_temp_warn} = '0;
      {i_temp_shut, i_spk_short, i_hp_short_pos, i_hp_short_neg} = '0;
      {i_drc_flags, i_seq_running, i_seq_queued, i_seq_done} = '0;
      {i_fw_clk_on, i_clk_need, i_clk_avail, i_clk_limit} = '0;
      i_rstn = 1'b0;
      tick(5);
      i_rstn <= 1'b1;
      tick(1);
      bus(0, status_flag_pkg::ADDR_CFG, 32'h0000_0000, 32'hffff_ffff);
      bus(0, status_flag_pkg::ADDR_EVT, 32'h0000_0000, 32'h0000_7fff);
      // pin selector: range control codes, then the table
      i_drc_flags <= 10'($random(seed));
      for (i = 0; i < 10; i++) begin
         bus(1, status_flag_pkg::ADDR_PIN, {24'h0, 8'h1D + 8'(i)}, 0);
         tick(2);
         cmp_pin(o_pin[0], i_drc_flags[i]);
      end
      for (i = 0; i < 16; i++) begin
         r = 10'($random(seed));
         {i_hp_short_neg, i_hp_short_pos, i_spk_short, i_temp_shut,
          i_temp_warn, i_isochronous_rate_converter_bad} <= r;
         bus(1, status_flag_pkg::ADDR_PIN, {24'h0, codes[i % 8]}, 0);
         tick(2);
         cmp_pin(o_pin[0], (i % 8) < 6 ? r[i % 8] : r[i % 8] | r[i % 8 + 2]);
      end
      {i_hp_short_neg, i_hp_short_pos, i_spk_short, i_temp_shut,
       i_temp_warn, i_isochronous_rate_converter_bad} <= 10'h000;
      tick(4);
      $display("test pins done");
      // rising edge latches and stays after the fall
      bus(1, status_flag_pkg::ADDR_EVT, 32'h0000_7fff, 0);
      i_isochronous_rate_converter_bad <= 3'b001;
      tick(2);
      i_isochronous_rate_converter_bad <= 3'b000;
      tick(2);
      bus(0, status_flag_pkg::ADDR_EVT, 32'h0000_0001, 32'h0000_0007);
      bus(1, status_flag_pkg::ADDR_EVT, 32'h0000_0000, 0);
      bus(0, status_flag_pkg::ADDR_EVT, 32'h0000_0001, 32'h0000_0001);
      bus(1, status_flag_pkg::ADDR_EVT, 32'h0000_0001, 0);
      bus(0, status_flag_pkg::ADDR_EVT, 32'h0000_0000, 32'h0000_0001);
      $display("test events done");
      // sequencer busy, completion pulse and event
      bus(1, status_flag_pkg::ADDR_PIN, 32'h0000_5615, 0);
      i_seq_running <= 1'b1;
      bus(0, status_flag_pkg::ADDR_RAW, 32'h0000_8000, 32'h0000_8000);
      i_seq_running <= 1'b0;
      i_seq_queued <= 1'b1;
      bus(0, status_flag_pkg::ADDR_RAW, 32'h0000_8000, 32'h0000_8000);
      h0 = w_high;
      r0 = w_rises;
      i_seq_queued <= 1'b0;
      i_seq_done <= 1'b1;
      tick(1);
      i_seq_done <= 1'b0;
      tick(8);
      cmp_reg(32'(w_rises - r0), 32'h0000_0001);
      cmp_reg(32'(w_high - h0), 32'(status_flag_pkg::PULSE_CYC));
      bus(0, status_flag_pkg::ADDR_RAW, 32'h0000_0000, 32'h0000_8000);
      bus(0, status_flag_pkg::ADDR_EVT, 32'h0000_0200, 32'h0000_0200);
      $display("test sequencer done");
      // overheat cut-off, late shutdown flag on pin one
      bus(1, status_flag_pkg::ADDR_EVT, 32'h0000_7fff, 0);
      i_temp_shut <= 1'b1;
      bus(0, status_flag_pkg::ADDR_RAW, 32'h0000_0000, 32'h0000_0100);
      tick(status_flag_pkg::SHUT_CYC + 4);
      cmp_pin(o_pin[1], 1'b1);
      cmp_pin(o_spk_enable, 1'b0);
      i_temp_shut <= 1'b0;
      tick(2);
      i_spk_short <= 1'b1;
      tick(2);
      cmp_pin(o_spk_enable, 1'b0);
      i_spk_short <= 1'b0;
      tick(10);
      bus(0, status_flag_pkg::ADDR_EVT, 32'h0000_0130, 32'h0000_0130);
      $display("test speaker done");
      // clocks first, then paths; starved path refused
      {i_clk_need, i_clk_avail, i_clk_limit} <= {8'h10, 8'h20, 8'h30};
      tick(2);
      bus(1, status_flag_pkg::ADDR_CFG, 32'h0000_0003, 0);
      tick(2);
      bus(0, status_flag_pkg::ADDR_RAW, 32'h0000_1800, 32'h0000_1800);
      bus(1, status_flag_pkg::ADDR_PIN, 32'h0000_4c4b, 0);
      cmp_pin(o_pin[0], 1'b1);
      cmp_pin(o_pin[1], 1'b1);
      bus(1, status_flag_pkg::ADDR_PATH, 32'h0000_0005, 0);
      cmp_reg({24'h0, o_path_active}, 32'h0000_0005);
      i_clk_avail <= 8'h08;
      tick(2);
      bus(1, status_flag_pkg::ADDR_PATH, 32'h0000_00ff, 0);
      cmp_reg({24'h0, o_path_active}, 32'h0000_0005);
      bus(0, status_flag_pkg::ADDR_RAW, 32'h0000_2000, 32'h0000_2000);
      bus(1, status_flag_pkg::ADDR_PIN, 32'h0000_270a, 0);
      cmp_pin(o_pin[0], 1'b1);
      cmp_pin(o_pin[1], 1'b0);
      bus(1, status_flag_pkg::ADDR_EVT, 32'h0000_7fff, 0);
      i_clk_avail <= 8'h20;
      tick(3);
      bus(0, status_flag_pkg::ADDR_EVT, 32'h0000_2000, 32'h0000_2000);
      i_clk_need <= 8'h40;
      tick(2);
      bus(0, status_flag_pkg::ADDR_RAW, 32'h0000_4000, 32'h0000_4000);
      bus(1, status_flag_pkg::ADDR_PIN, 32'h0000_2e0a, 0);
      cmp_pin(o_pin[0], 1'b0);
      cmp_pin(o_pin[1], 1'b1);
      bus(1, status_flag_pkg::ADDR_EVT, 32'h0000_7fff, 0);
      i_clk_need <= 8'h10;
      tick(3);
      bus(0, status_flag_pkg::ADDR_EVT, 32'h0000_4000, 32'h0000_4000);
      bus(1, status_flag_pkg::ADDR_CFG, 32'h0000_0000, 0);
      tick(status_flag_pkg::SHUT_CYC);
      bus(0, status_flag_pkg::ADDR_RAW, 32'h0000_0000, 32'h0000_1800);
      bus(0, status_flag_pkg::ADDR_EVT, 32'h0000_1800, 32'h0000_1800);
      $display("test clocks done");
      // bad address and firmware window without its clock
      bus(1, status_flag_pkg::ADDR_EVT, 32'h0000_7fff, 0);
      bus(1, status_flag_pkg::ADDR_PIN, 32'h0000_0016, 0);
      r0 = w_rises;
      bus(0, 12'h0f0, 32'h0000_0000, 32'h0000_0000);
      bus(0, status_flag_pkg::ADDR_EVT, 32'h0000_0400, 32'h0000_0400);
      cmp_reg(32'(w_rises - r0), 32'h0000_0001);
      bus(1, status_flag_pkg::ADDR_EVT, 32'h0000_0400, 0);
      bus(1, status_flag_pkg::ADDR_FWACC, 32'h0000_0001, 0);
      bus(0, status_flag_pkg::ADDR_EVT, 32'h0000_0400, 32'h0000_0400);
      bus(1, status_flag_pkg::ADDR_EVT, 32'h0000_0400, 0);
      i_fw_clk_on <= 1'b1;
      bus(0, status_flag_pkg::ADDR_FWACC, 32'h0000_0000, 32'h0000_0000);
      bus(0, status_flag_pkg::ADDR_EVT, 32'h0000_0000, 32'h0000_0400);
      $display("test interface done");
      tick(2);
      conclude();
   end
endmodule
`default_nettype wire
